// ---- rtl/hpsf_status_top.sv ----
// host port status flag bank with its spi access port
// assumes: event inputs are one-cycle pulses on the core clock; phy irq is asynchronous
//
// Functional notes
// - flag failed protected control write data, chunked mode only
// - flag bad host checksum, still transmit
// - three clearable timestamp-ready flags, slots a-c
// - phy flag set at reset exit, masked
// - reset done flag resets set, nonmaskable irq
// - extended status follows reset done flag
// - flag header parity failure in chunked mode
// - flag chip select lost mid transaction
// - protection error also raises deselect error
// - flag network receive buffer overflow
// - underrun only under cut-through, stops packet
// - report free space per protocol mode
// - overflow drops frame until next start
// - transmit fifo holds at least 4 kB
// - flag chunk start/data ordering violations
// - flag new size before previous completes, generic mode only
`timescale 1ns/1ps
module hpsf_status_top #(
  parameter int TX_FIFO_BYTES = hpsf_pkg::HPSF_TX_FIFO_BYTES, // host tx fifo size
  parameter int SPACE_W = $clog2(TX_FIFO_BYTES) + 1, // free space width
  parameter int FSIZE_W = 11 // frame size counter width, in words
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  input wire logic i_chunked_mode,
  input wire logic i_ctrl_protect_en,
  input wire logic i_host_cut_through_en,
  input wire logic i_phy_irq_unmask,
  input wire logic i_phy_irq,
  input wire logic i_tx_checksum_bad,
  input wire logic [2:0] i_stamp_captured,
  input wire logic i_net_rx_overflow,
  input wire logic i_tx_underrun_evt,
  input wire logic i_fifo_wr_req,
  input wire logic i_fifo_wr_sof,
  input wire logic i_fifo_full,
  input wire logic [SPACE_W-1:0] i_tx_free_space,
  input wire logic i_chunk_strobe,
  input wire logic i_chunk_data_valid,
  input wire logic i_chunk_start_valid,
  input wire logic i_chunk_end_valid,
  input wire logic i_fsize_write,
  input wire logic [FSIZE_W-1:0] i_fsize_words,
  input wire logic i_tx_word_write,
  output logic o_fifo_wr_en,
  output logic o_frame_discard,
  output logic o_tx_stop_pkt,
  output logic [SPACE_W-1:0] o_tx_credit_field,
  output logic [SPACE_W-1:0] o_tx_space_value,
  output logic o_extended_status_ind,
  output logic o_nonmask_irq_n,
  output logic o_phy_irq_req,
  output logic [31:0] o_status_word
);

  // decode of the one mapped register, used by read and write paths
  function automatic logic hits_host_interface_status_flags(input logic [5:0] a);
    hits_host_interface_status_flags = (a == hpsf_pkg::HPSF_HOST_INTERFACE_STATUS_FLAGS_ADDR);
  endfunction

  hpsf_reg_if bus ();

  // spi access port
  hpsf_spi_slave u_spi (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_sclk(i_spi_sclk),
    .i_spi_mosi(i_spi_mosi),
    .i_ctrl_protect_en(i_ctrl_protect_en),
    .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe(o_spi_miso_oe),
    .bus(bus)
  );

  logic [31:0] flags_reg; // clearable flag bits, ro bits held at zero here
  logic [31:0] flags_next;
  logic phy_sync1_reg; // first synchroniser stage, read only by stage 2
  logic phy_sync2_reg;
  logic phy_boot_reg; // phy flag forced on after reset until first status read
  logic drop_reg; // discarding writes until next start of frame
  logic in_frame_reg; // chunked: start seen, end pending
  logic [FSIZE_W-1:0] remain_reg; // generic: words still owed
  logic [FSIZE_W-1:0] remain_next;
  logic [SPACE_W-1:0] credit_reg;
  logic [SPACE_W-1:0] space_reg;
  logic [31:0] status_q_reg; // registered copy for the status output

  // phy interrupt comes from another clock domain
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phy_sync1_reg <= 1'b0;
      phy_sync2_reg <= 1'b0;
    end else begin
      phy_sync1_reg <= i_phy_irq;
      phy_sync2_reg <= phy_sync1_reg;
    end
  end

  // status word read and write decode
  wire st_wr = bus.wr_pulse & hits_host_interface_status_flags(bus.addr);
  wire st_rd = bus.rd_pulse & hits_host_interface_status_flags(bus.addr);
  wire [31:0] clr_vec = st_wr ? (bus.wdata & hpsf_pkg::HPSF_HOST_INTERFACE_STATUS_FLAGS_W1C_MASK) : 32'h00000000;

  wire ovf_evt = i_fifo_wr_req & i_fifo_full & (~drop_reg | i_fifo_wr_sof);
  wire drop_next = ovf_evt ? 1'b1 : ((i_fifo_wr_req & i_fifo_wr_sof) ? 1'b0 : drop_reg);
  wire under_evt = i_tx_underrun_evt & i_host_cut_through_en;
  // chunk ordering checks, chunked mode only
  wire dv_orphan = i_chunk_data_valid & ~i_chunk_start_valid & ~in_frame_reg;
  wire sv_repeat = i_chunk_start_valid & in_frame_reg & ~i_chunk_end_valid;
  wire chunk_err = i_chunked_mode & i_chunk_strobe & (dv_orphan | sv_repeat);
  wire in_frame_next = (i_chunked_mode & i_chunk_strobe) ?
                       (i_chunk_start_valid | (in_frame_reg & ~i_chunk_end_valid)) :
                       in_frame_reg;
  // new size while words still owed
  wire size_err = ~i_chunked_mode & i_fsize_write & (remain_reg != '0);
  wire proto_err = chunk_err | size_err;
  wire lof_set = bus.lof_err | bus.cdp_err;

  // event to flag set vector
  logic [31:0] set_vec;
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[hpsf_pkg::HPSF_BIT_CTRL_PROTECT_ERR] = bus.cdp_err & i_chunked_mode;
    set_vec[hpsf_pkg::HPSF_BIT_TX_CHECKSUM_ERR] = i_tx_checksum_bad;
    set_vec[hpsf_pkg::HPSF_BIT_TX_STAMP_READY_A] = i_stamp_captured[0];
    set_vec[hpsf_pkg::HPSF_BIT_TX_STAMP_READY_B] = i_stamp_captured[1];
    set_vec[hpsf_pkg::HPSF_BIT_TX_STAMP_READY_C] = i_stamp_captured[2];
    set_vec[hpsf_pkg::HPSF_BIT_HEADER_PARITY_ERR] = bus.hdr_err & i_chunked_mode;
    set_vec[hpsf_pkg::HPSF_BIT_EARLY_DESELECT_ERR] = lof_set;
    set_vec[hpsf_pkg::HPSF_BIT_NET_RX_OVERFLOW] = i_net_rx_overflow;
    set_vec[hpsf_pkg::HPSF_BIT_HOST_TX_UNDERRUN] = under_evt;
    set_vec[hpsf_pkg::HPSF_BIT_HOST_TX_OVERFLOW] = ovf_evt;
    set_vec[hpsf_pkg::HPSF_BIT_TX_PROTOCOL_ERR] = proto_err;
  end

  // set wins over a clear in the same cycle so no event is lost
  assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & hpsf_pkg::HPSF_HOST_INTERFACE_STATUS_FLAGS_W1C_MASK;

  // flag storage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= hpsf_pkg::HPSF_HOST_INTERFACE_STATUS_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // phy flag raised at reset exit
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phy_boot_reg <= 1'b1;
    end else if (st_rd) begin
      phy_boot_reg <= 1'b0;
    end
  end

  // readable word: ro phy bit merged, reserved bits zero
  logic [31:0] status_word;
  always_comb begin
    status_word = flags_reg;
    status_word[hpsf_pkg::HPSF_BIT_PORT1_PHY_IRQ] = phy_boot_reg | phy_sync2_reg;
  end
  // unmapped addresses read as zero
  assign bus.rdata = hits_host_interface_status_flags(bus.addr) ? status_word : 32'h00000000;

  // transmit frame tracking and fifo space reporting
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drop_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      remain_reg <= '0;
      credit_reg <= '0;
      space_reg <= '0;
      status_q_reg <= hpsf_pkg::HPSF_HOST_INTERFACE_STATUS_FLAGS_RESET;
    end else begin
      drop_reg <= drop_next;
      in_frame_reg <= in_frame_next;
      remain_reg <= remain_next;
      credit_reg <= i_chunked_mode ? i_tx_free_space : '0;
      space_reg <= i_chunked_mode ? '0 : i_tx_free_space;
      status_q_reg <= status_word;
    end
  end

  // generic mode words owed; a new size reloads even when flagged
  always_comb begin
    remain_next = remain_reg;
    if (i_fsize_write) begin
      remain_next = i_fsize_words;
    end else if (i_tx_word_write && remain_reg != '0) begin
      remain_next = remain_reg - 1'b1;
    end
  end

  // fifo write gating is a handshake, so combinational
  assign o_fifo_wr_en = i_fifo_wr_req & ~i_fifo_full & (~drop_reg | i_fifo_wr_sof);
  assign o_frame_discard = ovf_evt;
  assign o_tx_stop_pkt = under_evt;
  assign o_tx_credit_field = credit_reg;
  assign o_tx_space_value = space_reg;
  assign o_extended_status_ind = flags_reg[hpsf_pkg::HPSF_BIT_RESET_DONE_FLAG];
  assign o_nonmask_irq_n = ~flags_reg[hpsf_pkg::HPSF_BIT_RESET_DONE_FLAG];
  assign o_phy_irq_req = status_word[hpsf_pkg::HPSF_BIT_PORT1_PHY_IRQ] & i_phy_irq_unmask;
  assign o_status_word = status_q_reg;

  // protection error lands in both flags in chunked mode, else only in the deselect flag
  property p_cdp_both;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (bus.cdp_err && i_chunked_mode) |=> (flags_reg[12] && flags_reg[4]);
  endproperty
  a_cdp_both: assert property (p_cdp_both)
    else $error("protection error did not set both flags");

  property p_hdr_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n) (bus.hdr_err && i_chunked_mode) |=> flags_reg[5];
  endproperty
  a_hdr_flag: assert property (p_hdr_flag)
    else $error("header parity flag not set");

  property p_lof_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n) bus.lof_err |=> flags_reg[4];
  endproperty
  a_lof_flag: assert property (p_lof_flag)
    else $error("early deselect flag not set");

  property p_fcs_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n) i_tx_checksum_bad |=> flags_reg[11];
  endproperty
  a_fcs_flag: assert property (p_fcs_flag)
    else $error("checksum flag not set");

  property p_stamp_c;
    @(posedge i_core_clk) disable iff (!i_rst_n) i_stamp_captured[2] |=> flags_reg[10];
  endproperty
  a_stamp_c: assert property (p_stamp_c)
    else $error("timestamp slot c flag not set");

  property p_underrun_gate;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(flags_reg[2]) |-> $past(i_host_cut_through_en);
  endproperty
  a_underrun_gate: assert property (p_underrun_gate)
    else $error("underrun flagged without cut-through");

  property p_drop_until_sof;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ovf_evt ##1 (i_fifo_wr_req && !i_fifo_wr_sof) |-> !o_fifo_wr_en;
  endproperty
  a_drop_until_sof: assert property (p_drop_until_sof)
    else $error("write accepted after overflow before next start");

  property p_orphan_dv;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chunked_mode && i_chunk_strobe && i_chunk_data_valid && !i_chunk_start_valid
       && !in_frame_reg) |=> flags_reg[0];
  endproperty
  a_orphan_dv: assert property (p_orphan_dv)
    else $error("orphan data chunk not flagged");

  property p_zero_keeps;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_wr && !bus.wdata[11] && flags_reg[11]) |=> flags_reg[11];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("writing zero cleared a flag");

  property p_phy_masked;
    @(posedge i_core_clk) disable iff (!i_rst_n) !i_phy_irq_unmask |-> !o_phy_irq_req;
  endproperty
  a_phy_masked: assert property (p_phy_masked)
    else $error("masked phy flag drove irq");

  property p_extended_status_ind_tracks;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_wr && bus.wdata[6] && !set_vec[6]) |=> (!o_extended_status_ind && o_nonmask_irq_n);
  endproperty
  a_extended_status_ind_tracks: assert property (p_extended_status_ind_tracks)
    else $error("extended status or irq stayed after reset done cleared");

endmodule : hpsf_status_top

// ---- include/hpsf_pkg.sv ----
// host port status flags: shared offsets, field positions, reset values and spi framing
// assumes: one status register reached over the host spi port, 32-bit register words
package hpsf_pkg;

  // register map (word address carried in the spi header)
  localparam logic [5:0] HPSF_HOST_INTERFACE_STATUS_FLAGS_ADDR = 6'h08; // status flag register
  localparam logic [31:0] HPSF_HOST_INTERFACE_STATUS_FLAGS_RESET = 32'h00000040; // reset done set at reset
  localparam logic [31:0] HPSF_HOST_INTERFACE_STATUS_FLAGS_W1C_MASK = 32'h00001f7f; // clearable bits

  // field positions of the status word
  localparam int HPSF_BIT_CTRL_PROTECT_ERR = 12;
  localparam int HPSF_BIT_TX_CHECKSUM_ERR = 11;
  localparam int HPSF_BIT_TX_STAMP_READY_C = 10;
  localparam int HPSF_BIT_TX_STAMP_READY_B = 9;
  localparam int HPSF_BIT_TX_STAMP_READY_A = 8;
  localparam int HPSF_BIT_PORT1_PHY_IRQ = 7;
  localparam int HPSF_BIT_RESET_DONE_FLAG = 6;
  localparam int HPSF_BIT_HEADER_PARITY_ERR = 5;
  localparam int HPSF_BIT_EARLY_DESELECT_ERR = 4;
  localparam int HPSF_BIT_NET_RX_OVERFLOW = 3;
  localparam int HPSF_BIT_HOST_TX_UNDERRUN = 2;
  localparam int HPSF_BIT_HOST_TX_OVERFLOW = 1;
  localparam int HPSF_BIT_TX_PROTOCOL_ERR = 0;

  // spi transaction framing, counted in sclk rising edges
  localparam logic [6:0] HPSF_HDR_LAST = 7'd7; // last header bit index
  localparam logic [6:0] HPSF_DATA_FIRST = 7'd8; // first data bit index
  localparam logic [6:0] HPSF_DATA_LAST = 7'd39; // last data bit index
  localparam logic [6:0] HPSF_PROT_LAST = 7'd71; // last protection bit index

  // host transmit fifo size in bytes
  localparam int HPSF_TX_FIFO_BYTES = 4096;

endpackage : hpsf_pkg

// ---- include/hpsf_reg_if.sv ----
// register access carrier between the spi slave and the flag bank
// assumes: both ends on the core clock; all strobes are one-cycle pulses
`timescale 1ns/1ps
interface hpsf_reg_if;
  logic wr_pulse; // validated register write
  logic rd_pulse; // register read starts, rdata sampled now
  logic [5:0] addr; // word address from the header
  logic [31:0] wdata; // write data
  logic [31:0] rdata; // read data from the bank
  logic hdr_err; // header parity failed
  logic lof_err; // chip select lost mid transaction
  logic cdp_err; // protected write data failed its check

  // spi side drives access strobes and link errors
  modport spi (output wr_pulse, output rd_pulse, output addr, output wdata,
               output hdr_err, output lof_err, output cdp_err, input rdata);
  // flag bank side consumes them and returns read data
  modport regs (input wr_pulse, input rd_pulse, input addr, input wdata,
                input hdr_err, input lof_err, input cdp_err, output rdata);
endinterface : hpsf_reg_if

// ---- rtl/hpsf_spi_slave.sv ----
// spi slave for host register access, mode 0, msb first
// assumes: sclk, cs_n and mosi are asynchronous pins; core clock at least 8x sclk
`timescale 1ns/1ps
module hpsf_spi_slave (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  input wire logic i_ctrl_protect_en,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  hpsf_reg_if.spi bus
);

  // two-stage synchronisers, stage 1 read only by stage 2
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_d_reg; // delayed synced sclk for edges
  logic cs_d_reg; // delayed synced cs_n for edges
  logic [6:0] cnt_reg; // sclk rising edges seen this frame
  logic [31:0] sin_reg; // incoming shift register
  logic [31:0] sout_reg; // outgoing read data
  logic [31:0] whold_reg; // write data awaiting protection word
  logic [5:0] addr_reg;
  logic wnr_reg; // write not read
  logic done_reg; // frame reached its expected end
  logic skip_reg; // header rejected, rest ignored
  logic wr_reg, rd_reg, hdr_reg, lof_reg, cdp_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {i_spi_cs_n, i_spi_sclk, i_spi_mosi};
      sync2_reg <= sync1_reg;
    end
  end

  wire cs_n_s = sync2_reg[2];
  wire sclk_s = sync2_reg[1];
  wire mosi_s = sync2_reg[0];
  wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
  wire cs_release = cs_n_s & ~cs_d_reg;
  wire [31:0] sin_next = {sin_reg[30:0], mosi_s};
  wire hdr_end = sclk_rise & (cnt_reg == hpsf_pkg::HPSF_HDR_LAST) & ~skip_reg;
  // odd parity over the whole header byte
  wire hdr_ok = ^sin_next[7:0];
  wire data_end = sclk_rise & (cnt_reg == hpsf_pkg::HPSF_DATA_LAST) & ~skip_reg & ~done_reg;
  wire prot_end = sclk_rise & (cnt_reg == hpsf_pkg::HPSF_PROT_LAST) & ~skip_reg & ~done_reg;
  wire need_prot = wnr_reg & i_ctrl_protect_en;

  // edge history
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
    end
  end

  // bit counter and frame state, cleared while deselected
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 7'h00;
      sin_reg <= 32'h00000000;
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (cs_n_s) begin
      cnt_reg <= 7'h00;
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (sclk_rise) begin
      sin_reg <= sin_next;
      if (cnt_reg != 7'h7f) begin
        cnt_reg <= cnt_reg + 7'h01;
      end
      if (hdr_end && !hdr_ok) begin
        skip_reg <= 1'b1;
      end
      if ((hdr_end && hdr_ok && !sin_next[7]) || (data_end && !need_prot) || prot_end) begin
        done_reg <= 1'b1;
      end
    end
  end

  // header fields and held write data
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_reg <= 6'h00;
      wnr_reg <= 1'b0;
      whold_reg <= 32'h00000000;
    end else begin
      if (hdr_end && hdr_ok) begin
        wnr_reg <= sin_next[7];
        addr_reg <= sin_next[6:1];
      end
      if (data_end) begin
        whold_reg <= sin_next;
      end
    end
  end

  // read data shifted out on falling edges after the first data bit
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sout_reg <= 32'h00000000;
    end else if (hdr_end && hdr_ok && !sin_next[7]) begin
      sout_reg <= bus.rdata;
    end else if (sclk_fall && cnt_reg > hpsf_pkg::HPSF_DATA_FIRST) begin
      sout_reg <= {sout_reg[30:0], 1'b0};
    end
  end

  // one-cycle strobes to the flag bank
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {wr_reg, rd_reg, hdr_reg, lof_reg, cdp_reg} <= 5'h00;
    end else begin
      rd_reg <= 1'b0;
      wr_reg <= (data_end & wnr_reg & ~i_ctrl_protect_en) | (prot_end & (sin_next == ~whold_reg));
      hdr_reg <= hdr_end & ~hdr_ok;
      cdp_reg <= prot_end & (sin_next != ~whold_reg);
      lof_reg <= cs_release & (cnt_reg != 7'h00) & ~done_reg & ~skip_reg;
    end
  end

  assign bus.wr_pulse = wr_reg;
  // read request is combinational so rdata is captured in the header cycle
  assign bus.rd_pulse = hdr_end & hdr_ok & ~sin_next[7];
  assign bus.addr = (hdr_end & hdr_ok) ? sin_next[6:1] : addr_reg;
  assign bus.wdata = (cnt_reg > hpsf_pkg::HPSF_DATA_LAST) ? whold_reg : sin_reg;
  assign bus.hdr_err = hdr_reg;
  assign bus.lof_err = lof_reg;
  assign bus.cdp_err = cdp_reg;
  assign o_spi_miso = sout_reg[31];
  assign o_spi_miso_oe = ~cs_n_s & ~wnr_reg & (cnt_reg >= hpsf_pkg::HPSF_DATA_FIRST) & ~skip_reg;

  // a failed protected write must never also commit
  property p_cdp_blocks_write;
    @(posedge i_core_clk) disable iff (!i_rst_n) bus.cdp_err |-> !bus.wr_pulse;
  endproperty
  a_cdp_blocks_write: assert property (p_cdp_blocks_write)
    else $error("protected write committed despite check failure");

  // unused rd_reg kept constant for a clean reset image
  wire unused_rd = rd_reg;

endmodule : hpsf_spi_slave

// ---- verification/hpsf_host_model.sv ----
// spi host model: frames register reads and writes to the status bank
// assumes: mode 0 device, 48 ns sclk period, msb first, 40 or 72 bit frames
`timescale 1ns/1ps
module hpsf_host_model (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_miso
);
  // sclk stands still low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end

  // one frame; mode 1 spoils parity, mode 2 spoils the protection word
  task automatic xfer(input logic wr, input logic [31:0] d, input int nb, input int mode,
                      output logic [31:0] rd);
    logic [71:0] sh;
    sh = {wr, hpsf_pkg::HPSF_HOST_INTERFACE_STATUS_FLAGS_ADDR, 1'b0, d, ~d};
    sh[64] = ~^sh[71:65] ^ (mode == 1);
    if (mode == 2) sh[0] = ~sh[0];
    rd = '0;
    o_cs_n = 1'b0;
    #24;
    for (int i = 0; i < nb; i++) begin
      o_mosi = sh[71-i];
      #24 o_sclk = 1'b1;
      // read data sampled on the rise
      if (i >= 8 && i < 40) rd = {rd[30:0], i_miso};
      #24 o_sclk = 1'b0;
    end
    #24 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line shows no stale value
    #72;
  endtask
endmodule // hpsf_host_model

// ---- verification/hpsf_status_top_tb.sv ----
// testbench for the status flag bank: events, spi access and clearing
// assumes: host model on the spi pins, 250 MHz core clock
`timescale 1ns/1ps
module hpsf_status_top_tb;
  logic clk = 0, rst_n = 0, cs_n, sclk, mosi, miso, oe;
  logic chunked = 1, prot = 0, cut = 1, unmask = 0, phy = 0, chk_bad = 0, rx_ovf = 0;
  logic under = 0, strobe = 0, fsz = 0, wreq = 0, wsof = 0, full = 0;
  logic [2:0] stamp = 0;
  logic [12:0] free = 13'h123, credit, space;
  logic [10:0] fwords = 11'h002;
  logic wr_en, discard, stop, ext, irq_n, phy_req;
  logic [31:0] sw, exp, rd;
  int n_fail = 0, n_tests = 0;
  int fb[7] = '{11, 8, 9, 10, 3, 2, 0}; // flag bit of each event
  always #2 clk = ~clk;

  hpsf_status_top hpsf_status_top_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_spi_cs_n(cs_n),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe),
    .i_chunked_mode(chunked), .i_ctrl_protect_en(prot), .i_host_cut_through_en(cut),
    .i_phy_irq_unmask(unmask), .i_phy_irq(phy), .i_tx_checksum_bad(chk_bad),
    .i_stamp_captured(stamp), .i_net_rx_overflow(rx_ovf), .i_tx_underrun_evt(under),
    .i_fifo_wr_req(wreq), .i_fifo_wr_sof(wsof), .i_fifo_full(full), .i_tx_free_space(free),
    .i_chunk_strobe(strobe), .i_chunk_data_valid(1'b1), .i_chunk_start_valid(1'b0),
    .i_chunk_end_valid(1'b0), .i_fsize_write(fsz), .i_fsize_words(fwords),
    .i_tx_word_write(1'b0), .o_fifo_wr_en(wr_en), .o_frame_discard(discard),
    .o_tx_stop_pkt(stop), .o_tx_credit_field(credit), .o_tx_space_value(space),
    .o_extended_status_ind(ext), .o_nonmask_irq_n(irq_n), .o_phy_irq_req(phy_req),
    .o_status_word(sw));
  hpsf_host_model hpsf_host_model_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
    .i_miso(miso));

  // compare one value, count it
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // one-cycle pulse on the event inputs, then let the flags settle
  task ev(input logic [7:0] v);
    @(posedge clk);
    {fsz, strobe, under, rx_ovf, stamp, chk_bad} <= v;
    @(posedge clk);
    {fsz, strobe, under, rx_ovf, stamp, chk_bad} <= '0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // spi frame started off the clock edge to avoid races
  task spi(input logic wr, input logic [31:0] d, input int nb, input int mode);
    @(posedge clk);
    #1;
    hpsf_host_model_inst.xfer(wr, d, nb, mode, rd);
  endtask

  task tally_and_finish;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far beyond a dozen frames
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(sw, 32'hc0); // reset word
    chk(irq_n, 0); // irq asserted
    chk(ext, 1); // ext status set
    chk(phy_req, 0); // phy masked
    chk(credit, free); // credit shown
    spi(0, 0, 40, 0);
    chk(rd, 32'hc0); // read over spi
    spi(1, 32'hffffffff, 40, 0);
    chk(sw, 0); // ones clear
    chk(irq_n, 1); // irq released
    chk(ext, 0); // ext status drops
    $display("test reset done");
    exp = 0;
    for (int k = 0; k < 7; k++) begin
      ev(8'h01 << k);
      exp[fb[k]] = 1'b1;
      chk(sw, exp); // event flags
    end
    spi(1, ~exp, 40, 0);
    chk(sw, exp); // zeros and reserved ignored
    spi(1, exp, 40, 0);
    chk(sw, 0); // flags cleared
    @(posedge clk) cut <= 1'b0;
    ev(8'h20);
    chk(sw, 0); // no underrun flag
    @(posedge clk) chunked <= 1'b0;
    ev(8'h80);
    ev(8'h80);
    chk(sw, 1); // size rewritten early
    chk(space, free); // generic space
    chk(credit, 0); // no credit
    @(posedge clk) chunked <= 1'b1;
    $display("test events done");
    @(posedge clk);
    wreq <= 1'b1;
    full <= 1'b1;
    #1 chk(discard, 1); // frame dumped
    @(posedge clk) full <= 1'b0;
    #1 chk(wr_en, 0); // held off till sof
    @(posedge clk) wsof <= 1'b1;
    #1 chk(wr_en, 1); // resumes at sof
    @(posedge clk);
    wreq <= 1'b0;
    wsof <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(sw, 32'h3); // overflow flag
    $display("test overflow done");
    spi(0, 0, 40, 1);
    chk(sw, 32'h23); // parity flag
    // reads end after the header, so cut a write short
    spi(1, 0, 20, 0);
    chk(sw, 32'h33); // early deselect
    @(posedge clk) prot <= 1'b1;
    spi(1, 32'hffffffff, 72, 2);
    chk(sw, 32'h1033); // bad protection, write dropped
    spi(1, 32'hffffffff, 72, 0);
    chk(sw, 0); // protected write commits
    @(posedge clk) prot <= 1'b0;
    $display("test link done");
    @(posedge clk);
    phy <= 1'b1;
    unmask <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(phy_req, 1); // phy irq unmasked
    spi(0, 0, 40, 0);
    chk(rd, 32'h80); // host reads phy flag
    chk(oe, 0); // miso released after frame
    $display("test phy done");
    // a host underrun in cut-through stops the packet
    @(posedge clk);
    cut <= 1'b1;
    under <= 1'b1;
    #1 chk(stop, 1); // packet stopped
    @(posedge clk) under <= 1'b0;
    $display("test underrun done");
    tally_and_finish;
  end
endmodule // hpsf_status_top_tb
